// *** design/ssps_pkg.sv ***
/*
  ssps_pkg: constants, register map and state types for the synchronous
  serial port in spi mode.
  assumes a 100 MHz system clock and a 32-bit ahb-lite register bus.
*/
package ssps_pkg;

  // system clock rate and the bit clock divide ratios
  localparam int CLK_HZ = 100000000;
  localparam int DIV_FAST = 4;
  localparam int DIV_MID = 16;
  localparam int DIV_SLOW = 64;
  // half-period counts, minus one, for the divider compare
  localparam logic [4:0] HALF_FAST = 5'(DIV_FAST / 2 - 1);
  localparam logic [4:0] HALF_MID = 5'(DIV_MID / 2 - 1);
  localparam logic [4:0] HALF_SLOW = 5'(DIV_SLOW / 2 - 1);

  // byte addresses of the registers
  localparam logic [7:0] ADDR_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_BUFFER = 8'h10;
  localparam logic [7:0] ADDR_CONTROL = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h94;

  // serial_port_control fields
  localparam int CTL_WRITE_COLLISION_FLAG = 7;
  localparam int CTL_OVF = 6;
  localparam int CTL_EN = 5;
  localparam int CTL_CKP = 4;
  localparam int CTL_MODE_HI = 3;
  localparam int CTL_MODE_LO = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // serial_port_status fields
  localparam int STA_SMP = 7;
  localparam int STA_CKE = 6;
  localparam int STA_BF = 0;
  localparam logic [7:0] STA_RESET = 8'h00;

  // peripheral_flag_register field
  localparam int FLG_PIF = 3;

  // port_mode_field encodings
  localparam logic [3:0] MODE_M_DIV4 = 4'h0;
  localparam logic [3:0] MODE_M_DIV16 = 4'h1;
  localparam logic [3:0] MODE_M_DIV64 = 4'h2;
  localparam logic [3:0] MODE_M_TIMER_TWO_OUTPUT = 4'h3;
  localparam logic [3:0] MODE_S_SS = 4'h4;
  localparam logic [3:0] MODE_S_NOSS = 4'h5;

  // transfer framing
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [4:0] LAST_TOGGLE = 5'h10;
  localparam logic [4:0] FIRST_LATE_SHIFT = 5'h03;

  typedef enum logic [1:0] {
    SSPS_IDLE,
    SSPS_MASTER
  } ssps_mstate_t;

  typedef struct packed {
    logic write_collision_flag;
    logic ovf;
    logic en;
    logic clock_idle_polarity;
    logic [3:0] mode;
    logic input_sample_phase;
    logic cke;
    logic [7:0] rxbuf;
    logic bf;
    logic pif;
    logic [7:0] sr;
    logic samp;
    logic pend;
    logic [3:0] bitcnt;
    logic [4:0] tick;
    logic [4:0] div;
    logic sck;
    logic sck_prev;
    ssps_mstate_t state;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [7:0] rdata;
  } ssps_state_t;

endpackage : ssps_pkg

// *** design/ssps_spi.sv ***
/*
  ssps_spi: synchronous serial port, spi mode, with an ahb-lite slave for
  its registers. all logic of the block lives here.
  assumes pin inputs already synchronous to clock_i, timer_two_output_i a
  one-cycle pulse, and an external pad model resolving the enables.
*/

`timescale 1ns/10ps
`default_nettype none

module ssps_spi
  import ssps_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic serial_in_pin_i,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_o,
  input wire logic slave_select_n_i,
  input wire logic timer_two_output_i,
  output logic port_interrupt_flag_o,
  output logic port_owns_pins_o
);

  ssps_state_t st_q;
  ssps_state_t st_d;

  logic is_master;
  logic is_slave;
  logic slave_act;
  logic busy;
  logic addr_take;
  logic sck_rise;
  logic sck_fall;
  logic tx_on_rise;
  logic tx_edge;
  logic smp_edge;
  logic tick;
  logic [4:0] half;
  logic [4:0] tick_n;
  logic do_shift;
  logic do_sample;
  logic [7:0] byte_in;
  logic set_bf;
  logic set_pif;
  logic set_write_collision_flag;
  logic set_ovf;
  logic rd_buf;

  assign is_master = st_q.en && (st_q.mode == MODE_M_DIV4
    || st_q.mode == MODE_M_DIV16 || st_q.mode == MODE_M_DIV64
    || st_q.mode == MODE_M_TIMER_TWO_OUTPUT);
  assign is_slave = st_q.en && (st_q.mode == MODE_S_SS
    || st_q.mode == MODE_S_NOSS);
  assign slave_act = is_slave
    && (st_q.mode == MODE_S_NOSS || !slave_select_n_i);

  // a slave byte in progress still counts as busy for collisions
  assign busy = (st_q.state == SSPS_MASTER)
    || (is_slave && (st_q.bitcnt != 4'h0 || st_q.pend));

  assign addr_take = hsel_i && htrans_i[1] && hready_i;

  // edges seen on the pin; inputs are taken as already synchronous
  assign sck_rise = sck_i && !st_q.sck_prev;
  assign sck_fall = !sck_i && st_q.sck_prev;
  // transmit on rising when edge and polarity bits differ
  assign tx_on_rise = st_q.cke ^ st_q.clock_idle_polarity;
  assign tx_edge = tx_on_rise ? sck_rise : sck_fall;
  assign smp_edge = tx_on_rise ? sck_fall : sck_rise;

  always_comb begin
    unique case (st_q.mode)
      MODE_M_DIV16: half = HALF_MID;
      MODE_M_DIV64: half = HALF_SLOW;
      default: half = HALF_FAST;
    endcase
  end

  // half-period tick from divider or timer pulse
  assign tick = (st_q.state == SSPS_MASTER)
    && ((st_q.mode == MODE_M_TIMER_TWO_OUTPUT) ? timer_two_output_i
                                    : (st_q.div == half));
  assign tick_n = st_q.tick + 5'h01;

  // master: cke=0 samples odd edges, shifts on even ones;
  // cke=1 samples even edges, shifts on odd ones from the third,
  // with a last shift one half period after the sixteenth edge
  assign do_sample = tick && (st_q.cke ? (!tick_n[0]
    && tick_n <= LAST_TOGGLE) : tick_n[0]);
  assign do_shift = tick && (st_q.cke ? (tick_n[0]
    && tick_n >= FIRST_LATE_SHIFT) : !tick_n[0]);

  always_comb begin
    st_d = st_q;
    set_bf = 1'b0;
    set_pif = 1'b0;
    set_write_collision_flag = 1'b0;
    set_ovf = 1'b0;
    rd_buf = 1'b0;
    byte_in = 8'h00;
    st_d.sck_prev = sck_i;

    // register write in its data phase
    st_d.wr_pend = addr_take && hwrite_i;
    st_d.wr_addr = haddr_i[7:0];
    if (st_q.wr_pend) begin
      unique case (st_q.wr_addr)
        ADDR_CONTROL: begin
          st_d.write_collision_flag = hwdata_i[CTL_WRITE_COLLISION_FLAG];
          st_d.ovf = hwdata_i[CTL_OVF];
          st_d.en = hwdata_i[CTL_EN];
          st_d.clock_idle_polarity = hwdata_i[CTL_CKP];
          st_d.mode = hwdata_i[CTL_MODE_HI:CTL_MODE_LO];
        end
        ADDR_STATUS: begin
          // only the two top bits are writable
          st_d.input_sample_phase = hwdata_i[STA_SMP];
          st_d.cke = hwdata_i[STA_CKE];
        end
        ADDR_FLAGS: begin
          st_d.pif = hwdata_i[FLG_PIF];
        end
        ADDR_BUFFER: begin
          if (busy) begin
            set_write_collision_flag = 1'b1;
          end else if (is_master || is_slave) begin
            // first bit out before first edge
            st_d.sr = hwdata_i[7:0];
            st_d.pend = 1'b0;
            st_d.bitcnt = 4'h0;
            if (is_master) begin
              st_d.state = SSPS_MASTER;
              st_d.tick = 5'h00;
              st_d.div = 5'h00;
              st_d.sck = st_q.clock_idle_polarity;
            end
          end
        end
        default: begin
        end
      endcase
    end

    unique case (st_q.state)
      SSPS_IDLE: begin
        st_d.sck = st_q.clock_idle_polarity;
        st_d.tick = 5'h00;
        st_d.div = 5'h00;
        if (slave_act && smp_edge) begin
          if (st_q.bitcnt == LAST_BIT) begin
            // msb first, new bit enters at bit 0
            byte_in = {st_q.sr[6:0], serial_in_pin_i};
            st_d.sr = byte_in;
            st_d.bitcnt = 4'h0;
            st_d.pend = 1'b0;
            set_pif = 1'b1;
            if (st_q.bf) begin
              set_ovf = 1'b1;
            end else begin
              st_d.rxbuf = byte_in;
              set_bf = 1'b1;
            end
          end else begin
            st_d.samp = serial_in_pin_i;
            st_d.pend = 1'b1;
          end
        end else if (slave_act && tx_edge && st_q.pend) begin
          // one bit out, one bit in
          st_d.sr = {st_q.sr[6:0], st_q.samp};
          st_d.bitcnt = st_q.bitcnt + 4'h1;
          st_d.pend = 1'b0;
        end
        if (is_slave && st_q.mode == MODE_S_SS && slave_select_n_i) begin
          st_d.bitcnt = 4'h0;
          st_d.pend = 1'b0;
        end
      end
      SSPS_MASTER: begin
        st_d.div = (tick || st_q.mode == MODE_M_TIMER_TWO_OUTPUT) ? 5'h00
                                                      : st_q.div + 5'h01;
        if (tick) begin
          st_d.tick = tick_n;
          if (tick_n <= LAST_TOGGLE) begin
            st_d.sck = !st_q.sck;
          end
        end
        if (do_sample) begin
          st_d.samp = serial_in_pin_i;
        end
        if (do_shift) begin
          // end-of-bit sampling takes the pin at the shift edge
          byte_in = {st_q.sr[6:0],
                     st_q.input_sample_phase ? serial_in_pin_i : st_q.samp};
          st_d.sr = byte_in;
          st_d.bitcnt = st_q.bitcnt + 4'h1;
          if (st_q.bitcnt == LAST_BIT) begin
            st_d.rxbuf = byte_in;
            st_d.bitcnt = 4'h0;
            st_d.state = SSPS_IDLE;
            st_d.sck = st_q.clock_idle_polarity;
            set_bf = 1'b1;
            set_pif = 1'b1;
          end
        end
      end
      default: begin
        st_d.state = SSPS_IDLE;
      end
    endcase

    // disabled or non-spi mode: shifter held idle
    if (!is_master && !is_slave) begin
      st_d.state = SSPS_IDLE;
      st_d.bitcnt = 4'h0;
      st_d.pend = 1'b0;
    end

    // hardware only sets; set beats a same-cycle clear
    if (set_write_collision_flag) begin
      st_d.write_collision_flag = 1'b1;
    end
    if (set_ovf) begin
      st_d.ovf = 1'b1;
    end
    if (set_pif) begin
      st_d.pif = 1'b1;
    end

    // read data captured at the address phase, after same-cycle updates
    if (addr_take && !hwrite_i) begin
      unique case (haddr_i[7:0])
        ADDR_CONTROL: st_d.rdata = {st_d.write_collision_flag, st_d.ovf, st_d.en,
                                    st_d.clock_idle_polarity, st_d.mode};
        ADDR_STATUS: st_d.rdata = {st_d.input_sample_phase, st_d.cke, 5'h00,
                                   st_d.bf | set_bf};
        ADDR_FLAGS: st_d.rdata = {4'h0, st_d.pif, 3'h0};
        ADDR_BUFFER: begin
          st_d.rdata = st_d.rxbuf;
          rd_buf = 1'b1;
        end
        default: st_d.rdata = 8'h00;
      endcase
    end

    // read empties buffer; a fresh load wins
    if (set_bf) begin
      st_d.bf = 1'b1;
    end else if (rd_buf) begin
      st_d.bf = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // zero wait states; errors are never signalled
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = {24'h000000, st_q.rdata};

  assign sck_o = st_q.sck;
  // pins handed to the port only when enabled
  assign sck_oe_o = is_master;
  assign serial_out_pin_o = st_q.sr[7];
  // select high floats serial out at once
  assign serial_out_pin_oe_o = is_master || slave_act;
  assign port_interrupt_flag_o = st_q.pif;
  assign port_owns_pins_o = st_q.en;

endmodule : ssps_spi

`default_nettype wire

// *** testbench/ssps_props.sv ***
/* ssps_props: port checks for ssps_spi.
   assumes one ahb master; attached by the bind at the foot. */
`timescale 1ns/10ps
`default_nettype none
module ssps_props
  import ssps_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic sck_o,
  input wire logic sck_oe_o,
  input wire logic serial_out_pin_oe_o,
  input wire logic slave_select_n_i,
  input wire logic port_interrupt_flag_o,
  input wire logic port_owns_pins_o
);
  logic [7:0] wa_q, ctl_q;
  logic wv_q, rv_q, run_q, sck_q, tk, mst;
  logic [4:0] tog_q;
  assign tk = hsel_i && htrans_i[1] && hready_i;
  assign mst = ctl_q[CTL_EN] && ctl_q[3:0] < MODE_S_SS;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wa_q <= 8'h00;
      ctl_q <= 8'h00;
      {wv_q, rv_q, run_q, sck_q} <= 4'h0;
      tog_q <= 5'h00;
    end else begin
      wv_q <= tk && hwrite_i;
      rv_q <= tk && !hwrite_i;
      if (tk) wa_q <= haddr_i[7:0];
      if (wv_q && wa_q == ADDR_CONTROL) ctl_q <= hwdata_i[7:0];
      sck_q <= sck_o;
      tog_q <= tog_q + 5'(run_q && sck_o != sck_q);
      if (port_interrupt_flag_o || !mst) run_q <= 1'b0;
      // count restarts only on an accepted start, not on a collision
      if (wv_q && wa_q == ADDR_BUFFER && mst && !run_q) begin
        run_q <= 1'b1;
        tog_q <= 5'h00;
      end
    end
  end
  property p_pins_free;
    !port_owns_pins_o [*2] |-> !sck_oe_o && !serial_out_pin_oe_o;
  endproperty
  a_pins_free: assert property (p_pins_free)
    else $error("pins driven while port off");
  property p_sel_float;
    (ctl_q[CTL_EN] && ctl_q[3:0] == MODE_S_SS && slave_select_n_i) [*2]
      |-> !serial_out_pin_oe_o;
  endproperty
  a_sel_float: assert property (p_sel_float)
    else $error("serial out driven while deselected");
  property p_non_spi;
    (ctl_q[CTL_EN] && ctl_q[3:0] > MODE_S_NOSS) [*2]
      |-> !sck_oe_o && !serial_out_pin_oe_o;
  endproperty
  a_non_spi: assert property (p_non_spi)
    else $error("pins driven in a non-spi mode");
  property p_master_drv;
    mst [*2] |-> sck_oe_o && serial_out_pin_oe_o;
  endproperty
  a_master_drv: assert property (p_master_drv)
    else $error("master not driving clock and data");
  property p_sixteen;
    // the sixteenth toggle can land on the completing edge, not yet counted
    $rose(port_interrupt_flag_o) && run_q
      |-> tog_q + 5'(sck_o != sck_q) == 5'h10;
  endproperty
  a_sixteen: assert property (p_sixteen)
    else $error("master byte without sixteen clock edges");
  property p_idle_lvl;
    (sck_oe_o && !run_q && $stable(ctl_q)) [*2]
      |-> sck_o == ctl_q[CTL_CKP];
  endproperty
  a_idle_lvl: assert property (p_idle_lvl)
    else $error("idle clock level wrong");
  property p_rd_upper;
    rv_q |-> hrdata_o[31:8] == 24'h000000;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("read data upper bits not zero");
  property p_flag_hold;
    port_interrupt_flag_o && !(wv_q && wa_q == ADDR_FLAGS)
      |=> port_interrupt_flag_o;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("interrupt flag dropped without a write");
endmodule : ssps_props
bind ssps_spi ssps_props ssps_props_inst (.clock_i, .rstn_i, .hsel_i,
  .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hrdata_o, .sck_o,
  .sck_oe_o, .serial_out_pin_oe_o, .slave_select_n_i,
  .port_interrupt_flag_o, .port_owns_pins_o);
`default_nettype wire

// *** testbench/ssps_slave_model.sv ***
/* ssps_slave_model: spi device on the far side of the port.
   assumes cke_i and ckp_i match the port; load_i pulses before a frame. */
`timescale 1ns/10ps
`default_nettype none
module ssps_slave_model (
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic cke_i,
  input wire logic ckp_i,
  input wire logic load_i,
  input wire logic [7:0] tx_i,
  output logic miso_o,
  output logic [7:0] rx_o
);
  logic [7:0] tx_q;
  int n;
  assign miso_o = tx_q[7];
  always @(posedge load_i) begin
    tx_q = tx_i;
    n = 0;
  end
  // shift on transmit edge, latch on the other
  always @(sck_i) begin
    n = n + 1;
    if (sck_i == (cke_i ^ ckp_i)) begin
      if (n > 1) tx_q = {tx_q[6:0], ~tx_q[0]};
    end else begin
      rx_o = {rx_o[6:0], mosi_i};
    end
  end
endmodule : ssps_slave_model
`default_nettype wire

// *** testbench/ssps_spi_tb.sv ***
/* ssps_spi_tb: self-checking bench for ssps_spi.
   assumes a zero-wait ahb slave and the spi device model on the link. */
`timescale 1ns/10ps
`default_nettype none
module ssps_spi_tb
  import ssps_pkg::*;
;
  typedef struct packed {
    logic [3:0] mode;
    logic clock_idle_polarity, cke, input_sample_phase;
    logic [7:0] mtx, stx;
  } ssps_row_t;
  ssps_row_t rows [4] = '{'{MODE_M_DIV4, 1'b0, 1'b0, 1'b0, 8'ha5, 8'h3c},
    '{MODE_M_DIV16, 1'b1, 1'b0, 1'b1, 8'h81, 8'h7e},
    '{MODE_M_DIV64, 1'b0, 1'b1, 1'b0, 8'h01, 8'h80},
    '{MODE_M_TIMER_TWO_OUTPUT, 1'b1, 1'b1, 1'b1, 8'hc3, 8'h96}};
  logic [7:0] adr [4] = '{ADDR_CONTROL, ADDR_STATUS, ADDR_FLAGS, 8'h40};
  logic clock_i, rstn_i, hsel, hwrite, tsck, ss_n, tmr, pload, hrdy, pif;
  logic sck_o, sck_oe, serial_out_pin, sdo_oe, miso, own, pcke, pckp, sck_w;
  logic [1:0] htrans, tcnt;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [7:0] ptx, prx;
  int n_mismatch, num_checks;
  assign sck_w = sck_oe ? sck_o : tsck;
  ssps_spi ssps_spi_inst (.clock_i, .rstn_i, .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(), .hrdata_o(hrdata),
    .sck_i(sck_w), .sck_o, .sck_oe_o(sck_oe), .serial_in_pin_i(miso),
    .serial_out_pin_o(serial_out_pin), .serial_out_pin_oe_o(sdo_oe),
    .slave_select_n_i(ss_n), .timer_two_output_i(tmr),
    .port_interrupt_flag_o(pif), .port_owns_pins_o(own));
  ssps_slave_model ssps_slave_model_inst (.sck_i(sck_w), .mosi_i(serial_out_pin),
    .cke_i(pcke), .ckp_i(pckp), .load_i(pload), .tx_i(ptx), .miso_o(miso),
    .rx_o(prx));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    tcnt <= tcnt + 2'h1;
    tmr <= tcnt == 2'h3;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic waitc(input int lim);
    int k;
    @(posedge clock_i);
    for (k = 0; pif !== 1'b1 && hrdy !== 1'bz; k++) begin
      if (k == lim) n_mismatch++;
      if (k == lim) stop_test();
      @(posedge clock_i);
    end
  endtask : waitc
  task automatic rdy();
    int k;
    @(posedge clock_i);
    for (k = 0; hrdy !== 1'b1; k++) begin
      if (k == 20) n_mismatch++;
      if (k == 20) stop_test();
      @(posedge clock_i);
    end
  endtask : rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    rdy();
    r = hrdata;
  endtask : bus
  task automatic cfg(input logic input_sample_phase, cke, clock_idle_polarity, input logic [3:0] m);
    pcke <= cke;
    pckp <= clock_idle_polarity;
    bus(1'b1, ADDR_STATUS, {input_sample_phase, cke, 6'h00});
    bus(1'b1, ADDR_CONTROL, {3'b001, clock_idle_polarity, m});
    bus(1'b0, ADDR_BUFFER, 8'h00);
  endtask : cfg
  task automatic start(input logic [7:0] m, s);
    ptx <= s;
    pload <= 1'b1;
    @(posedge clock_i);
    pload <= 1'b0;
    bus(1'b1, ADDR_BUFFER, m);
  endtask : start
  task automatic sclk(input int n);
    repeat (n) begin
      repeat (3) @(posedge clock_i);
      tsck <= ~tsck;
    end
    repeat (3) @(posedge clock_i);
  endtask : sclk
  task automatic done(input logic [7:0] m, s, sta);
    waitc(2000);
    chk({24'h0, prx}, {24'h0, m});
    bus(1'b0, ADDR_STATUS, 8'h00);
    chk(r, {24'h0, sta});
    bus(1'b0, ADDR_BUFFER, 8'h00);
    chk(r, {24'h0, s});
    bus(1'b0, ADDR_STATUS, 8'h00);
    chk({31'h0, r[0]}, 32'h0);
    bus(1'b1, ADDR_FLAGS, 8'h00);
  endtask : done
  initial begin
    {hsel, hwrite, tsck, pload, pcke, pckp, tmr, rstn_i} = 8'h00;
    {htrans, tcnt, haddr, hwdata, ptx} = 76'h0;
    ss_n = 1'b1;
    n_mismatch = 0;
    num_checks = 0;
    repeat (12) @(posedge clock_i);
    rstn_i <= 1'b1;
    foreach (adr[i]) begin
      bus(1'b0, adr[i], 8'h00);
      chk(r, 32'h0);
    end
    bus(1'b1, ADDR_STATUS, 8'hff);
    bus(1'b0, ADDR_STATUS, 8'h00);
    chk(r, 32'hc0);
    foreach (rows[i]) begin
      cfg(rows[i].input_sample_phase, rows[i].cke, rows[i].clock_idle_polarity, rows[i].mode);
      start(rows[i].mtx, rows[i].stx);
      done(rows[i].mtx, rows[i].stx, {rows[i].input_sample_phase, rows[i].cke, 6'h01});
    end
    cfg(1'b0, 1'b0, 1'b0, MODE_M_DIV4);
    start(8'h55, 8'haa);
    bus(1'b1, ADDR_BUFFER, 8'h00);
    waitc(2000);
    chk({24'h0, prx}, 32'h55);
    bus(1'b1, ADDR_FLAGS, 8'h00);
    start(8'h66, 8'h99);
    waitc(2000);
    bus(1'b0, ADDR_CONTROL, 8'h00);
    chk(r, 32'ha0);
    cfg(1'b0, 1'b0, 1'b0, MODE_S_NOSS);
    start(8'h3c, 8'ha5);
    sclk(16);
    waitc(50);
    chk({24'h0, prx}, 32'h3c);
    bus(1'b1, ADDR_FLAGS, 8'h00);
    start(8'h00, 8'h5a);
    sclk(16);
    waitc(50);
    bus(1'b0, ADDR_CONTROL, 8'h00);
    chk(r, 32'h65);
    bus(1'b0, ADDR_BUFFER, 8'h00);
    chk(r, 32'ha5);
    bus(1'b0, ADDR_CONTROL, 8'h00);
    chk(r, 32'h65);
    ss_n <= 1'b0;
    cfg(1'b0, 1'b1, 1'b0, MODE_S_SS);
    start(8'h0f, 8'hf0);
    sclk(4);
    ss_n <= 1'b1;
    repeat (2) @(posedge clock_i);
    chk({31'h0, sdo_oe}, 32'h0);
    ss_n <= 1'b0;
    start(8'h0f, 8'h69);
    sclk(16);
    waitc(50);
    bus(1'b0, ADDR_BUFFER, 8'h00);
    chk(r, 32'h69);
    bus(1'b1, ADDR_CONTROL, 8'h26);
    bus(1'b0, ADDR_CONTROL, 8'h00);
    chk({30'h0, sck_oe, sdo_oe}, 32'h0);
    bus(1'b1, ADDR_CONTROL, 8'h00);
    #1;
    chk({31'h0, own}, 32'h0);
    stop_test();
  end
endmodule : ssps_spi_tb
`default_nettype wire
